//--- perf_event_regs.vh
/*
 * Event codes, unit masks and field widths for the event selector.
 * Assumes the includer uses these as 8-bit compares.
 */
// What this block does
// - Count retired loads hitting fill buffer
// - Count translation-miss loads, excluding faulting ones
// - Translation misses: only cacheable, no prefetch
// - Count first float after packed-int
// - Count first packed-int after float
// - Count transitions both ways
// - Count every decoded instruction
// - Count decoder stall cycles, invert selected
// - Count microcode sequencer micro-ops
// - Count stack pointer folding instructions
// - Count stack pointer sync operations
// - Count flag stall cycles
// - Detect partial flag stall from flag masks
`ifndef PERF_EVENT_REGS_VH
`define PERF_EVENT_REGS_VH
`define EV_MEM_LOAD      8'hCB
`define EV_FP_PI_TRANS   8'hCC
`define EV_INST_DECODED  8'hD0
`define EV_UOPS_DECODED  8'hD1
`define EV_ALLOC_STALLS  8'hD2
`define UM_FILL_HIT      8'h40
`define UM_XLAT_MISS     8'h80
`define UM_TO_FLOAT      8'h01
`define UM_TO_PACKED     8'h02
`define UM_EITHER_WAY    8'h03
`define UM_DECODED       8'h01
`define UM_DEC_STALL     8'h01
`define UM_SEQ_UOPS      8'h02
`define UM_SP_FOLD       8'h04
`define UM_SP_SYNC       8'h08
`define UM_FLAG_STALL    8'h01
`define SEQ_UOP_LIMIT    4
`define FLAG_WIDTH       6
`define COUNT_WIDTH      48
`endif

//--- partial_flag_detect.v
/*
 * Partial flag stall detector.
 * Assumes one flag writer and one flag reader slot per cycle, same clock.
 */
`default_nettype none
`include "perf_event_regs.vh"
module partial_flag_detect #(
	parameter FW = `FLAG_WIDTH
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          reset_i,
	// Flag writer
	input  wire          wr_valid_i,
	input  wire [FW-1:0] wr_mask_i,
	// Flag reader
	input  wire          rd_valid_i,
	input  wire [FW-1:0] rd_mask_i,
	// Result
	output reg           stall_o
);
	reg          partial_r;
	reg [FW-1:0] stale_r;
	wire         wr_partial;
	wire         hit;
	assign wr_partial = wr_valid_i && (wr_mask_i != {FW{1'b1}}) && (wr_mask_i != {FW{1'b0}});
	assign hit = rd_valid_i && partial_r && ((rd_mask_i & stale_r) != {FW{1'b0}});
	always @(posedge clk_i) begin
		if (reset_i) begin
			partial_r <= 1'b0;
			stale_r   <= {FW{1'b0}};
			stall_o   <= 1'b0;
		end else begin
			stall_o <= hit;
			// Only the next flag reader is judged against the last writer
			if (wr_valid_i) begin
				partial_r <= wr_partial;
				stale_r   <= ~wr_mask_i;
			end else if (rd_valid_i) begin
				partial_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- core_perf_event_select.v
/*
 * Event selection and counter for one core performance counter.
 * Assumes pipeline strobes are single-cycle levels on CLK_I.
 */
`default_nettype none
`include "perf_event_regs.vh"
module core_perf_event_select #(
	parameter CW = `COUNT_WIDTH,
	parameter FW = `FLAG_WIDTH
) (
	// Clock and reset
	input  wire          CLK_I,
	input  wire          RESET_I,
	// Selection
	input  wire [7:0]    EVENT_CODE_I,
	input  wire [7:0]    UNIT_MASK_I,
	input  wire          INVERT_COMPARE_I,
	input  wire          COUNT_CLEAR_I,
	// Retired loads
	input  wire          LOAD_RETIRE_I,
	input  wire          LOAD_L1_MISS_I,
	input  wire          LOAD_FILL_BUFFER_HIT_I,
	input  wire          LOAD_XLAT_MISS_I,
	input  wire          LOAD_FAULT_I,
	input  wire          LOAD_CACHEABLE_I,
	input  wire          LOAD_SW_PREFETCH_I,
	// Floating / packed-int issue
	input  wire          FLOAT_INST_I,
	input  wire          PACKED_INT_INST_I,
	// Decoder
	input  wire          INST_DECODED_I,
	input  wire          DECODER_STALL_I,
	input  wire          SEQ_UOP_I,
	input  wire          SP_FOLD_I,
	input  wire          SP_SYNC_I,
	// Allocation stalls and flags
	input  wire          ALLOC_STALL_I,
	input  wire          FLAG_WR_VALID_I,
	input  wire [FW-1:0] FLAG_WR_MASK_I,
	input  wire          FLAG_RD_VALID_I,
	input  wire [FW-1:0] FLAG_RD_MASK_I,
	// Counter
	output reg  [CW-1:0] COUNT_O,
	output reg           INCREMENT_O
);
	//--------------------------------------------
	// Mode tracking
	//--------------------------------------------
	localparam ST_NONE   = 2'd0;
	localparam ST_FLOAT  = 2'd1;
	localparam ST_PACKED = 2'd2;
	reg  [1:0] mode_r;
	reg  [1:0] mode_nxt;
	reg        to_float;
	reg        to_packed;
	wire       flag_stall;
	reg        hit;
	always @* begin
		mode_nxt  = mode_r;
		to_float  = 1'b0;
		to_packed = 1'b0;
		case (mode_r)
			ST_NONE: begin
				if (FLOAT_INST_I)
					mode_nxt = ST_FLOAT;
				else if (PACKED_INT_INST_I)
					mode_nxt = ST_PACKED;
			end
			ST_FLOAT: begin
				if (PACKED_INT_INST_I) begin
					to_packed = 1'b1;
					mode_nxt  = ST_PACKED;
				end
			end
			ST_PACKED: begin
				if (FLOAT_INST_I) begin
					to_float = 1'b1;
					mode_nxt = ST_FLOAT;
				end
			end
			default: mode_nxt = ST_NONE;
		endcase
	end
	//--------------------------------------------
	// Flag stall detector
	//--------------------------------------------
	partial_flag_detect #(
		.FW (FW)
	) u_flag (
		.clk_i      (CLK_I),
		.reset_i    (RESET_I),
		.wr_valid_i (FLAG_WR_VALID_I),
		.wr_mask_i  (FLAG_WR_MASK_I),
		.rd_valid_i (FLAG_RD_VALID_I),
		.rd_mask_i  (FLAG_RD_MASK_I),
		.stall_o    (flag_stall)
	);
	//--------------------------------------------
	// Event selection
	//--------------------------------------------
	always @* begin
		hit = 1'b0;
		case (EVENT_CODE_I)
			`EV_MEM_LOAD: begin
				if (UNIT_MASK_I == `UM_FILL_HIT)
					hit = LOAD_RETIRE_I && LOAD_L1_MISS_I && LOAD_FILL_BUFFER_HIT_I;
				else if (UNIT_MASK_I == `UM_XLAT_MISS)
					hit = LOAD_RETIRE_I && LOAD_XLAT_MISS_I && !LOAD_FAULT_I &&
					      LOAD_CACHEABLE_I && !LOAD_SW_PREFETCH_I;
			end
			`EV_FP_PI_TRANS: begin
				if (UNIT_MASK_I == `UM_TO_FLOAT)
					hit = to_float;
				else if (UNIT_MASK_I == `UM_TO_PACKED)
					hit = to_packed;
				else if (UNIT_MASK_I == `UM_EITHER_WAY)
					hit = to_float || to_packed;
			end
			`EV_INST_DECODED: begin
				if (UNIT_MASK_I == `UM_DECODED)
					hit = INST_DECODED_I;
			end
			`EV_UOPS_DECODED: begin
				if (UNIT_MASK_I == `UM_DEC_STALL)
					hit = DECODER_STALL_I ^ INVERT_COMPARE_I;
				else if (UNIT_MASK_I == `UM_SEQ_UOPS)
					hit = SEQ_UOP_I;
				else if (UNIT_MASK_I == `UM_SP_FOLD)
					hit = SP_FOLD_I;
				else if (UNIT_MASK_I == `UM_SP_SYNC)
					hit = SP_SYNC_I;
			end
			`EV_ALLOC_STALLS: begin
				if (UNIT_MASK_I == `UM_FLAG_STALL)
					hit = ALLOC_STALL_I || flag_stall;
			end
			default: hit = 1'b0;
		endcase
	end
	//--------------------------------------------
	// Counter
	//--------------------------------------------
	always @(posedge CLK_I) begin
		if (RESET_I) begin
			mode_r      <= ST_NONE;
			COUNT_O     <= {CW{1'b0}};
			INCREMENT_O <= 1'b0;
		end else begin
			mode_r      <= mode_nxt;
			INCREMENT_O <= hit;
			// One per clock; clear with an increment loads 1
			if (hit)
				COUNT_O <= COUNT_CLEAR_I ? {{(CW-1){1'b0}}, 1'b1} : COUNT_O + 1'b1;
			else if (COUNT_CLEAR_I)
				COUNT_O <= {CW{1'b0}};
		end
	end
endmodule
`default_nettype wire

//--- perf_sel_assertions.sv
/* Checker for the event selector's ports.
 * Assumes one clock and a synchronous active-high reset. */
`default_nettype none
module perf_sel_check #(
	parameter CW = 48
) (
	input wire logic          CLK_I, RESET_I, INVERT_COMPARE_I, COUNT_CLEAR_I,
	input wire logic [7:0]    EVENT_CODE_I, UNIT_MASK_I,
	input wire logic          LOAD_RETIRE_I, LOAD_L1_MISS_I, LOAD_FILL_BUFFER_HIT_I,
	input wire logic          LOAD_FAULT_I, LOAD_CACHEABLE_I, LOAD_SW_PREFETCH_I,
	input wire logic          FLOAT_INST_I, PACKED_INT_INST_I, INST_DECODED_I,
	input wire logic          DECODER_STALL_I, SEQ_UOP_I, SP_FOLD_I, SP_SYNC_I,
	input wire logic [CW-1:0] COUNT_O,
	input wire logic          INCREMENT_O
);
	wire [15:0] sel = {EVENT_CODE_I, UNIT_MASK_I};
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	sequence s_float; FLOAT_INST_I && !PACKED_INT_INST_I; endsequence
	sequence s_quiet; !FLOAT_INST_I && !PACKED_INT_INST_I; endsequence
	sequence s_packed; sel == 16'hCC02 && PACKED_INT_INST_I && !FLOAT_INST_I; endsequence
	a_decode_count: assert property (sel == 16'hD001 && INST_DECODED_I
		|=> INCREMENT_O) else $error("decode missed");
	a_seq_count: assert property (sel == 16'hD102 && SEQ_UOP_I
		|=> INCREMENT_O) else $error("sequencer uop missed");
	a_fold_count: assert property (sel == 16'hD104 && SP_FOLD_I
		|=> INCREMENT_O) else $error("fold missed");
	a_sync_count: assert property (sel == 16'hD108 && SP_SYNC_I
		|=> INCREMENT_O) else $error("sync missed");
	a_stall_invert: assert property (sel == 16'hD101 && (DECODER_STALL_I != INVERT_COMPARE_I)
		|=> INCREMENT_O) else $error("stall missed");
	a_fill_hit: assert property (sel == 16'hCB40 && LOAD_RETIRE_I && LOAD_L1_MISS_I
		&& LOAD_FILL_BUFFER_HIT_I |=> INCREMENT_O) else $error("fill hit missed");
	a_xlat_skip: assert property (sel == 16'hCB80 && (LOAD_FAULT_I || !LOAD_CACHEABLE_I
		|| LOAD_SW_PREFETCH_I) |=> !INCREMENT_O) else $error("excluded load counted");
	a_count_step: assert property (!COUNT_CLEAR_I
		|=> COUNT_O == $past(COUNT_O) + INCREMENT_O) else $error("count step wrong");
	a_clear_zero: assert property (COUNT_CLEAR_I
		|=> COUNT_O == INCREMENT_O) else $error("clear wrong");
	a_to_packed: assert property (s_float ##1 s_quiet[*2] ##1 s_packed
		|=> INCREMENT_O) else $error("transition missed");
endmodule
bind core_perf_event_select perf_sel_check #(.CW(CW)) u_check (.*);
`default_nettype wire

//--- core_pipe_model.sv
/* Pipeline stand-in raising per-cycle event strobes.
 * Assumes the bench loads the strobe word after a rising edge. */
`default_nettype none
module core_pipe_model (
	// Clock
	input  wire logic        clk_i,
	// Strobe word in, strobes out
	input  wire logic [28:0] req_i,
	output var  logic [28:0] ev_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ev_o = '0;
	// Falling edge keeps strobes clear of sampling
	always @(negedge clk_i) begin
		ev_o <= req_i;
	end
endmodule
`default_nettype wire

//--- core_perf_event_select_test.sv
/* Bench for the event selector: selection table, then hand cases.
 * Assumes the pipeline model and checker are compiled first. */
`default_nettype none
module core_perf_event_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] s; logic [28:0] v; logic inc;} row_t;
	logic clk = 0, rst = 1, invert_compare = 0, clr = 0;
	logic [15:0] sel = '0;
	logic [28:0] req = '0;
	logic [47:0] expc = '0;
	wire logic [28:0] ev;
	wire logic [47:0] cnt;
	wire logic inc;
	int n_errors = 0, checked = 0;
	row_t rows[21];
	always #10 clk = ~clk;
	core_pipe_model u_pipe (.clk_i(clk), .req_i(req), .ev_o(ev));
	core_perf_event_select u_dut (.CLK_I(clk), .RESET_I(rst), .EVENT_CODE_I(sel[15:8]),
		.UNIT_MASK_I(sel[7:0]), .INVERT_COMPARE_I(invert_compare), .COUNT_CLEAR_I(clr),
		.LOAD_RETIRE_I(ev[0]), .LOAD_L1_MISS_I(ev[1]), .LOAD_FILL_BUFFER_HIT_I(ev[2]),
		.LOAD_XLAT_MISS_I(ev[3]), .LOAD_FAULT_I(ev[4]), .LOAD_CACHEABLE_I(ev[5]),
		.LOAD_SW_PREFETCH_I(ev[6]), .FLOAT_INST_I(ev[7]), .PACKED_INT_INST_I(ev[8]),
		.INST_DECODED_I(ev[9]), .DECODER_STALL_I(ev[10]), .SEQ_UOP_I(ev[11]),
		.SP_FOLD_I(ev[12]), .SP_SYNC_I(ev[13]), .ALLOC_STALL_I(ev[14]),
		.FLAG_WR_VALID_I(ev[15]), .FLAG_RD_VALID_I(ev[16]), .FLAG_WR_MASK_I(ev[22:17]),
		.FLAG_RD_MASK_I(ev[28:23]), .COUNT_O(cnt), .INCREMENT_O(inc));
	task automatic chk(input string nm, input logic [47:0] got, exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic drive(input logic [28:0] v);
		@(posedge clk);
		req = v;
	endtask
	task automatic run(input row_t r);
		@(negedge clk);
		sel = r.s;
		drive(r.v);
		drive('0);
		@(negedge clk);
		expc = expc + r.inc;
		chk("increment", inc, r.inc);
		chk("count", cnt, expc);
	endtask
	// Flag write, reader of flag 2, then the one-cycle detector delay
	task automatic flag(input logic [28:0] w, input logic add);
		drive(w);
		drive(29'h0201_0000);
		repeat (3) drive('0);
		@(negedge clk);
		expc = expc + add;
		chk("flag count", cnt, expc);
	endtask
	task automatic finish_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Run needs about 80 cycles; over eighteen times that is a hang
	initial begin
		#30us;
		n_errors++;
		finish_test();
	end
	initial begin
		rows = '{'{16'hCB40, 29'h0000_0007, 1}, '{16'hCB40, 29'h0000_0005, 0},
			'{16'hCB80, 29'h0000_0029, 1}, '{16'hCB80, 29'h0000_0039, 0},
			'{16'hCB80, 29'h0000_0069, 0}, '{16'hCB80, 29'h0000_0009, 0},
			'{16'hD001, 29'h0000_0200, 1}, '{16'hD101, 29'h0000_0400, 1},
			'{16'hD102, 29'h0000_0800, 1}, '{16'hD104, 29'h0000_1000, 1},
			'{16'hD104, 29'h0000_2000, 0}, '{16'hD108, 29'h0000_2000, 1},
			'{16'hD201, 29'h0000_4000, 1}, '{16'h0000, 29'h0000_7E7F, 0},
			'{16'hCC02, 29'h0000_0080, 0}, '{16'hCC02, 29'h0000_0100, 1},
			'{16'hCC02, 29'h0000_0100, 0}, '{16'hCC01, 29'h0000_0080, 1},
			'{16'hCC01, 29'h0000_0080, 0}, '{16'hCC03, 29'h0000_0100, 1},
			'{16'hCC03, 29'h0000_0080, 1}};
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 0;
		chk("reset count", cnt, '0);
		chk("reset increment", inc, '0);
		foreach (rows[i]) run(rows[i]);
		sel = 16'hD201;
		flag(29'h0006_8000, 1);
		flag(29'h007E_8000, 0);
		sel = 16'hD101;
		invert_compare = 1;
		@(negedge clk);
		sel = '0;
		invert_compare = 0;
		@(negedge clk);
		expc = expc + 1;
		chk("inverted stall", cnt, expc);
		sel = 16'hD001;
		drive(29'h0000_0200);
		@(negedge clk);
		clr = 1;
		drive('0);
		@(negedge clk);
		clr = 0;
		chk("clear count", cnt, 48'h0000_0000_0001);
		rst = 1;
		@(negedge clk);
		rst = 0;
		chk("second reset", cnt, '0);
		finish_test();
	end
endmodule
`default_nettype wire
